// File: verilog/external_irq_sense_priority.sv
// External request sense, status, enable and priority-level registers.
// Assumes an APB master on pclk and request pins that idle high.
//
// Summary of operation
// R01: Priority bit clear means level 0, set means level 1; reset clear.
// R02: First priority register bits map requests 0..7, transfer unit, watchdog.
// R03: Second priority register: bit 6 converter, bits 5..3 timer units 0..2.
// R04: Third priority register: bits 7,6 byte timers, bits 4..2 serial 0..2.
// R05: Enable bit n gates request n; 0 off, 1 on.
// R06: Enable register clears on reset and hardware standby.
// R07: Sense pair holds field B at 2n+1, field A at 2n.
// R08: Sense codes: 00 low, 01 falling, 10 rising, 11 both edges.
// R09: Sense registers clear on reset and standby, giving low-level sensing.
// R10: Status register clears on reset and hardware standby.
// R11: Software clears a flag only by writing 0 after reading it as 1.
// R12: Status writes only clear; software never sets a flag.
// R13: Low-level mode: exception handling clears flag while input is high.
// R14: Edge modes: exception handling clears the flag.
// R15: Transfer activation clears the flag unless clear-disable is set.
// R16: Low-level mode sets the flag while the input is low.
// R17: Falling mode sets the flag on a high-to-low transition.
// R18: Rising mode sets the flag on a low-to-high transition.
// R19: Both-edge mode sets the flag on either transition.
// R20: Flags set regardless of the enable register.
// R21: Priority registers clear on reset and hardware standby.
// R22: Request forwarded while flag and enable are both one, with level.
// R23: Inputs synchronised; edges found by comparing successive samples.
`timescale 1ns/1ns
module external_irq_sense_priority
  import irq_front_pkg::*;
#(
  parameter int NUM_REQ = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_standby,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request pins, active low
  input wire logic [NUM_REQ-1:0] external_request_input_n,
  // Exception handling and transfer controller events
  input wire ack_event_t exc_ack,
  input wire ack_event_t xfer_act,
  input wire logic transfer_clear_disable,
  // Requests toward arbitration
  output logic [NUM_REQ-1:0] request_out,
  output logic [NUM_REQ-1:0] request_level,
  // Priority levels of internal sources
  output logic prio_xfer,
  output logic prio_wdog,
  output logic prio_adc,
  output logic [2:0] prio_tpu,
  output logic [1:0] prio_tmr,
  output logic [2:0] prio_serial
);

  front_state_t s_q;
  front_state_t s_d;

  // Bus decode helpers
  logic setup_ph;
  logic access_ph;
  logic wr_ok;
  logic rd_ok;
  logic mapped;

  // Per-request condition helpers
  logic [NUM_REQ-1:0] ev;
  logic [NUM_REQ-1:0] hit_low;
  logic [NUM_REQ-1:0] hit_fall;
  logic [NUM_REQ-1:0] hit_rise;
  logic [NUM_REQ-1:0] hit_both;
  logic [NUM_REQ-1:0] clr_sw;
  logic [NUM_REQ-1:0] clr_hw;

  // Zero-wait-state slave; read data is latched in the setup cycle
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = access_ph;
  assign wr_ok = access_ph && pwrite && !s_q.err;
  assign rd_ok = access_ph && !pwrite && !s_q.err;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.err;

  // Address map check
  always_comb begin
    case (paddr)
      OFS_ENABLE, OFS_SENSE, OFS_STATUS: mapped = 1'b1;
      OFS_PRIO_A, OFS_PRIO_B, OFS_PRIO_C: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Sense decode on synchronised samples, one field per request
  always_comb begin
    for (int n = 0; n < NUM_REQ; n++) begin
      hit_low[n] = 1'b0;
      hit_fall[n] = 1'b0;
      hit_rise[n] = 1'b0;
      hit_both[n] = 1'b0;
      case (s_q.sense[2*n +: 2])  // R07
        SENSE_LOW: hit_low[n] = !s_q.sync2[n];  // R16 R08
        SENSE_FALL: hit_fall[n] = s_q.prev[n] && !s_q.sync2[n];  // R17 R23
        SENSE_RISE: hit_rise[n] = !s_q.prev[n] && s_q.sync2[n];  // R18
        SENSE_BOTH: hit_both[n] = s_q.prev[n] ^ s_q.sync2[n];  // R19
        default: hit_low[n] = 1'b0;
      endcase
    end
    // Flags set independent of the enable register
    ev = hit_low | hit_fall | hit_rise | hit_both;  // R20
  end

  // Hardware clear sources: exception handling and transfer activation
  always_comb begin
    clr_hw = '0;
    for (int n = 0; n < NUM_REQ; n++) begin
      if (exc_ack.valid && exc_ack.num == 3'(n)) begin
        if (s_q.sense[2*n +: 2] != SENSE_LOW) begin
          clr_hw[n] = 1'b1;  // R14
        end else if (s_q.sync2[n]) begin
          clr_hw[n] = 1'b1;  // R13
        end
      end
      if (xfer_act.valid && xfer_act.num == 3'(n) &&
          !transfer_clear_disable) begin
        clr_hw[n] = 1'b1;  // R15
      end
    end
  end

  // Software clear: only zeros written to flags already read as one
  always_comb begin
    clr_sw = '0;
    if (wr_ok && paddr == OFS_STATUS && pstrb[0]) begin
      clr_sw = s_q.seen & ~pwdata[NUM_REQ-1:0];  // R11 R12
    end
  end

  // Next-state logic for registers, flags and synchronisers
  always_comb begin
    s_d = s_q;
    // Two-stage synchroniser, then previous sample for edge compare
    s_d.sync1 = external_request_input_n;  // R23
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;

    // Set wins over software and event clears in the same cycle; standby wins over set
    s_d.flag = (s_q.flag & ~(clr_sw | clr_hw)) | ev;  // R12

    // Remember which flags software has seen as one
    if (rd_ok && paddr == OFS_STATUS) begin
      s_d.seen = s_q.seen | s_q.rdata[NUM_REQ-1:0];  // R11
    end
    if (wr_ok && paddr == OFS_STATUS && pstrb[0]) begin
      s_d.seen = RST_BYTE;
    end

    // Register writes take effect at the access edge
    if (wr_ok) begin
      case (paddr)
        OFS_ENABLE: begin
          if (pstrb[0]) begin
            s_d.ena = pwdata[7:0];  // R05
          end
        end
        OFS_SENSE: begin
          if (pstrb[0]) begin
            s_d.sense[7:0] = pwdata[7:0];  // R07
          end
          if (pstrb[1]) begin
            s_d.sense[15:8] = pwdata[15:8];
          end
        end
        OFS_PRIO_A: begin
          if (pstrb[0]) begin
            s_d.prio_a = pwdata[7:0] & MASK_PRIO_A;  // R02
          end
        end
        OFS_PRIO_B: begin
          if (pstrb[0]) begin
            s_d.prio_b = pwdata[7:0] & MASK_PRIO_B;  // R03
          end
        end
        OFS_PRIO_C: begin
          if (pstrb[0]) begin
            s_d.prio_c = pwdata[7:0] & MASK_PRIO_C;  // R04
          end
        end
        default: s_d.ena = s_q.ena;
      endcase
    end

    // Read data and error are prepared in the setup cycle
    if (setup_ph) begin
      s_d.err = !mapped;
      s_d.rdata = RST_WORD;
      case (paddr)
        OFS_ENABLE: s_d.rdata[7:0] = s_q.ena;
        OFS_SENSE: s_d.rdata[15:0] = s_q.sense;
        OFS_STATUS: s_d.rdata[7:0] = s_q.flag;
        OFS_PRIO_A: s_d.rdata[7:0] = s_q.prio_a;
        OFS_PRIO_B: s_d.rdata[7:0] = s_q.prio_b;
        OFS_PRIO_C: s_d.rdata[7:0] = s_q.prio_c;
        default: s_d.rdata = RST_WORD;
      endcase
    end

    // Hardware standby returns every mapped register and the seen flags to reset; synchronisers and read data keep updating
    if (hw_standby) begin
      s_d.ena = RST_BYTE;  // R06
      s_d.sense = RST_SENSE;  // R09
      s_d.flag = RST_BYTE;  // R10
      s_d.seen = RST_BYTE;
      s_d.prio_a = RST_BYTE;  // R21
      s_d.prio_b = RST_BYTE;
      s_d.prio_c = RST_BYTE;
    end
  end

  // State register; pins idle high so samples reset high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.ena <= RST_BYTE;  // R06
      s_q.sense <= RST_SENSE;  // R09
      s_q.flag <= RST_BYTE;  // R10
      s_q.seen <= RST_BYTE;
      s_q.prio_a <= RST_BYTE;  // R01 R21
      s_q.prio_b <= RST_BYTE;
      s_q.prio_c <= RST_BYTE;
      s_q.sync1 <= RST_SYNC;
      s_q.sync2 <= RST_SYNC;
      s_q.prev <= RST_SYNC;
      s_q.rdata <= RST_WORD;
      s_q.err <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Forward requests gated by enable
  assign request_out = s_q.flag & s_q.ena;  // R22 R05

  // Request groups share priority bits
  assign request_level[0] = s_q.prio_a[PA_REQ0];  // R02 R01
  assign request_level[1] = s_q.prio_a[PA_REQ1];
  assign request_level[2] = s_q.prio_a[PA_REQ23];
  assign request_level[3] = s_q.prio_a[PA_REQ23];
  assign request_level[4] = s_q.prio_a[PA_REQ45];
  assign request_level[5] = s_q.prio_a[PA_REQ45];
  assign request_level[6] = s_q.prio_a[PA_REQ67];
  assign request_level[7] = s_q.prio_a[PA_REQ67];
  assign prio_xfer = s_q.prio_a[PA_XFER];
  assign prio_wdog = s_q.prio_a[PA_WDOG];

  // Internal source levels; channel index grows as bit index falls
  assign prio_adc = s_q.prio_b[PB_ADC];  // R03
  assign prio_tpu[0] = s_q.prio_b[PB_TPU0];
  assign prio_tpu[1] = s_q.prio_b[PB_TPU0-1];
  assign prio_tpu[2] = s_q.prio_b[PB_TPU0-2];
  assign prio_tmr[0] = s_q.prio_c[PC_TMR0];  // R04
  assign prio_tmr[1] = s_q.prio_c[PC_TMR0-1];
  assign prio_serial[0] = s_q.prio_c[PC_SER0];
  assign prio_serial[1] = s_q.prio_c[PC_SER0-1];
  assign prio_serial[2] = s_q.prio_c[PC_SER0-2];

  // Checks on the flag and register behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_LOW_SETS: assert property ( // R16
    |hit_low |=> ($past(hit_low) & s_q.flag) == $past(hit_low)
      || $past(hw_standby))
    else $error("low level did not set flag");

  AST_FALL_SETS: assert property ( // R17
    |hit_fall && !hw_standby |=> ($past(hit_fall) & s_q.flag) ==
      $past(hit_fall))
    else $error("falling edge did not set flag");

  AST_RISE_SETS: assert property ( // R18
    |hit_rise && !hw_standby |=> ($past(hit_rise) & s_q.flag) ==
      $past(hit_rise))
    else $error("rising edge did not set flag");

  AST_BOTH_SETS: assert property ( // R19
    |hit_both && !hw_standby |=> ($past(hit_both) & s_q.flag) ==
      $past(hit_both))
    else $error("edge in both mode did not set flag");

  AST_NO_SW_SET: assert property ( // R12
    ev == '0 |=> (s_q.flag & ~$past(s_q.flag)) == '0)
    else $error("flag rose without a sense event");

  // Status clears checked on every request, not one fixed bit
  AST_SW_CLEAR: assert property ( // R11
    wr_ok && paddr == OFS_STATUS && pstrb[0] |=> (s_q.flag &
      $past(s_q.seen) & ~$past(pwdata[NUM_REQ-1:0]) & ~$past(ev)) == '0)
    else $error("write of zero after read did not clear flag");

  AST_EDGE_EXC_CLEAR: assert property ( // R14
    exc_ack.valid && !ev[exc_ack.num] &&
      s_q.sense[2*exc_ack.num +: 2] != SENSE_LOW |=>
      !s_q.flag[$past(exc_ack.num)])
    else $error("exception handling left edge flag set");

  AST_XFER_CLEAR: assert property ( // R15
    xfer_act.valid && !transfer_clear_disable && !ev[xfer_act.num] |=>
      !s_q.flag[$past(xfer_act.num)])
    else $error("transfer activation left flag set");

  AST_STANDBY: assert property ( // R06
    hw_standby |=> s_q.ena == RST_BYTE && s_q.sense == RST_SENSE &&
      s_q.flag == RST_BYTE && s_q.prio_a == RST_BYTE)
    else $error("standby did not clear registers");

  AST_FORWARD: assert property ( // R22
    request_out[2] |-> s_q.flag[2] && s_q.ena[2] &&
      request_level[2] == request_level[3])
    else $error("request forwarded without flag and enable");

  // One copy per request so a random request number is always covered
  for (genvar g = 0; g < NUM_REQ; g++) begin : gen_sync_chk
    AST_SYNC_DELAY: assert property ( // R23
      s_q.sense[2*g +: 2] == SENSE_FALL && $fell(s_q.sync2[g]) &&
        !hw_standby |-> hit_fall[g] ##1 s_q.flag[g])
      else $error("synchronised falling edge missed");
  end

endmodule

// File: verilog/irq_front_pkg.sv
// Package for the external request sense and priority front end.
// Assumes a 32-bit APB slave and eight active-low request pins.
package irq_front_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_SENSE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PRIO_A = 8'h0C;
  localparam logic [7:0] OFS_PRIO_B = 8'h10;
  localparam logic [7:0] OFS_PRIO_C = 8'h14;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_SENSE = 16'h0000;
  localparam logic [7:0] RST_SYNC = 8'hFF;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Implemented bits of the priority registers; the rest read zero
  localparam logic [7:0] MASK_PRIO_A = 8'hFE;
  localparam logic [7:0] MASK_PRIO_B = 8'h78;
  localparam logic [7:0] MASK_PRIO_C = 8'hDC;

  // Field positions in the priority registers
  localparam int PA_REQ0 = 7;
  localparam int PA_REQ1 = 6;
  localparam int PA_REQ23 = 5;
  localparam int PA_REQ45 = 4;
  localparam int PA_REQ67 = 3;
  localparam int PA_XFER = 2;
  localparam int PA_WDOG = 1;
  localparam int PB_ADC = 6;
  localparam int PB_TPU0 = 5;
  localparam int PC_TMR0 = 7;
  localparam int PC_SER0 = 4;

  // Sense field encoding, field B then field A
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  // Whole state of the front end
  typedef struct packed {
    logic [7:0] ena;
    logic [15:0] sense;
    logic [7:0] flag;
    logic [7:0] seen;
    logic [7:0] prio_a;
    logic [7:0] prio_b;
    logic [7:0] prio_c;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [31:0] rdata;
    logic err;
  } front_state_t;

  // Interrupt handling and transfer controller events
  typedef struct packed {
    logic valid;
    logic [2:0] num;
  } ack_event_t;

endpackage

// File: tb/irq_pin_model.sv
// Model of the request pins and the CPU side handling events.
// Assumes the bench calls its tasks; all changes follow a pclk edge.
`timescale 1ns/1ns
module irq_pin_model
  import irq_front_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Toward the block
  output logic [7:0] pins_n,
  output ack_event_t exc_ack,
  output ack_event_t xfer_act,
  output logic clear_disable
);
  // Pins idle high, no events pending
  initial begin
    pins_n = 8'hFF;
    exc_ack = '0;
    xfer_act = '0;
    clear_disable = 1'b0;
  end

  // Pin levels change right after an edge
  task automatic drive(input logic [7:0] v);
    @(posedge pclk);
    pins_n <= v;
  endtask

  // One-cycle handling or transfer pulse; option only meaningful with it
  task automatic pulse(input logic xfer, input logic [2:0] n,
                       input logic dis);
    @(posedge pclk);
    if (xfer) begin
      xfer_act <= '{1'b1, n};
    end else begin
      exc_ack <= '{1'b1, n};
    end
    clear_disable <= dis;
    @(posedge pclk);
    exc_ack <= '0;
    xfer_act <= '0;
    clear_disable <= ~dis; // Inverted once the pulse is gone
  endtask
endmodule

// File: tb/external_irq_sense_priority_bench.sv
// Self-checking bench for the request sense and priority front end.
// Assumes zero-wait APB and a three-edge pin-to-flag latency.
`timescale 1ns/1ns
module external_irq_sense_priority_bench
  import irq_front_pkg::*;
;
  logic pclk, presetn, hw_standby, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, pins_n, request_out, request_level;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [2:0] prio_tpu, prio_serial;
  logic [1:0] prio_tmr;
  logic prio_xfer, prio_wdog, prio_adc, clear_disable, rerr;
  ack_event_t exc_ack, xfer_act;
  int error_cnt = 0;
  int checks_done = 0;
  logic [7:0] mflag, mena, a, b, c;
  logic [15:0] msense;
  int n, m;
  logic [7:0] ofs [6] = '{OFS_ENABLE, OFS_SENSE, OFS_STATUS, OFS_PRIO_A,
                          OFS_PRIO_B, OFS_PRIO_C};

  external_irq_sense_priority external_irq_sense_priority_inst (
    .pclk(pclk), .presetn(presetn), .hw_standby(hw_standby), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_request_input_n(pins_n), .exc_ack(exc_ack),
    .xfer_act(xfer_act), .transfer_clear_disable(clear_disable),
    .request_out(request_out), .request_level(request_level),
    .prio_xfer(prio_xfer), .prio_wdog(prio_wdog), .prio_adc(prio_adc),
    .prio_tpu(prio_tpu), .prio_tmr(prio_tmr), .prio_serial(prio_serial));
  irq_pin_model irq_pin_model_inst (.pclk(pclk), .pins_n(pins_n),
    .exc_ack(exc_ack), .xfer_act(xfer_act), .clear_disable(clear_disable));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rdat, exp);
    chk(rerr, 1'b0);
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // Software clear: read the flag as one, then write zero to it
  task automatic sw_clear(input int i);
    rd(OFS_STATUS, mflag);
    wr(OFS_STATUS, ~(32'h1 << i));
    mflag[i] = 1'b0;
  endtask

  initial begin
    {psel, penable, pwrite, hw_standby} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    presetn = 1'b0;
    mflag = 8'h00;
    void'($urandom(32'hD741));
    idle(16);
    presetn <= 1'b1;
    // Reset values and an unmapped address
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    $display("test reset done");
    // Priority levels: random values, masked read-back and outputs
    a = $urandom;
    b = $urandom;
    c = $urandom;
    wr(OFS_PRIO_A, a);
    wr(OFS_PRIO_B, b);
    wr(OFS_PRIO_C, c);
    rd(OFS_PRIO_A, a & MASK_PRIO_A);
    rd(OFS_PRIO_B, b & MASK_PRIO_B);
    rd(OFS_PRIO_C, c & MASK_PRIO_C);
    chk(request_level, {a[3], a[3], a[4], a[4], a[5], a[5], a[6], a[7]});
    chk({prio_xfer, prio_wdog, prio_adc, prio_tpu},
        {a[2], a[1], b[6], b[3], b[4], b[5]});
    chk({prio_tmr, prio_serial}, {c[6], c[7], c[2], c[3], c[4]});
    $display("test priority done");
    // Byte lanes: only the lower sense byte is written
    pstrb <= 4'h1;
    wr(OFS_SENSE, 32'h5555);
    pstrb <= 4'hF;
    rd(OFS_SENSE, 32'h0055);
    // Every sense mode on a random request, random enables
    mena = $urandom;
    wr(OFS_ENABLE, mena);
    rd(OFS_ENABLE, mena);
    for (m = 0; m < 4; m++) begin
      n = $urandom % 8;
      msense = 16'(m) << (2 * n);
      wr(OFS_SENSE, msense);
      rd(OFS_SENSE, msense);
      irq_pin_model_inst.drive(~(8'h01 << n));
      idle(4);
      mflag[n] = (m != 2);
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, mflag);
      chk(request_out, mflag & mena);
      irq_pin_model_inst.drive(8'hFF);
      idle(4);
      mflag[n] = mflag[n] | (m >= 2);
      rd(OFS_STATUS, mflag);
      sw_clear(n);
      rd(OFS_STATUS, mflag);
      wr(OFS_STATUS, 32'hFF);
      rd(OFS_STATUS, mflag);
    end
    $display("test sense done");
    // Clears by exception handling and transfer activation
    n = $urandom % 8;
    wr(OFS_SENSE, 16'(SENSE_FALL) << (2 * n));
    irq_pin_model_inst.drive(~(8'h01 << n));
    idle(4);
    irq_pin_model_inst.pulse(1'b0, n[2:0], 1'b0);
    idle(2);
    rd(OFS_STATUS, mflag);
    irq_pin_model_inst.drive(8'hFF);
    irq_pin_model_inst.drive(~(8'h01 << n));
    idle(4);
    mflag[n] = 1'b1;
    irq_pin_model_inst.pulse(1'b1, n[2:0], 1'b1);
    idle(2);
    rd(OFS_STATUS, mflag);
    irq_pin_model_inst.pulse(1'b1, n[2:0], 1'b0);
    idle(2);
    mflag[n] = 1'b0;
    rd(OFS_STATUS, mflag);
    wr(OFS_SENSE, 32'h0);
    idle(4);
    mflag[n] = 1'b1;
    irq_pin_model_inst.pulse(1'b0, n[2:0], 1'b0);
    idle(2);
    rd(OFS_STATUS, mflag);
    irq_pin_model_inst.drive(8'hFF);
    idle(4);
    irq_pin_model_inst.pulse(1'b0, n[2:0], 1'b0);
    idle(2);
    mflag[n] = 1'b0;
    rd(OFS_STATUS, mflag);
    $display("test clear events done");
    // Hardware standby clears every register
    wr(OFS_ENABLE, 32'hFF);
    wr(OFS_SENSE, 32'hFFFF);
    wr(OFS_PRIO_A, 32'hFF);
    @(posedge pclk);
    hw_standby <= 1'b1;
    @(posedge pclk);
    hw_standby <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    chk(request_out, 8'h00);
    $display("test standby done");
    results();
  end
endmodule
